//--- src/ccp_ctrl.sv
`default_nettype none
// Functional notes
// R01 - Every data and L2 line holds a two-bit four-state coherency status.
// R02 - Fixed encoding of modified, exclusive, shared, invalid; invalid after reset.
// R03 - Instruction lines track only shared or invalid.
// R04 - Data writes invalidate matching instruction lines to keep code consistent.
// R05 - M, E, S count as valid; only M makes memory stale.
// R06 - M and E are unique to us; S and I may be elsewhere.
// R07 - Writes to M/E stay local; S writes go to bus and cache; I to bus.
// R08 - Fill-disable clear enables caching, subject to page restrictions.
// R09 - Fill-disable set blocks fills and updates but snoops still answered; write hits still raise o_cache_update here.
// R10 - Fill-disable set keeps read hits and write invalidation working.
// R11 - Fill-disable alone does not force strict ordering.
// R12 - Software flushes after setting fill-disable and keeps both bits clear.
// R13 - Both global bits clear gives write-back policy by default.
// R14 - Page cache-disable honoured only with paging on and fill-disable clear.
// R15 - Page write-through honoured only with paging on and write-through bit clear.
// R16 - Directory base attributes govern directory accesses under the same gating.
// R17 - Normal mode: hits cached, misses fill, S writes and misses reach memory.
// R18 - Fill-disable 0 with write-through 1 raises protection fault, code zero.
// R19 - Fill-disable only: contents frozen, coherency kept, invalidation allowed.
// R20 - Both bits set: no coherency, write hits skip memory, misses reach memory.
// R21 - Both bits set: write hit turns E into M, S stays S.
module ccp_ctrl
  import ccp_pkg::*;
#(
  parameter int unsigned LINES = CCP_LINES,
  parameter int unsigned IDX_W = CCP_IDX_W
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Global and page controls
  input wire logic [31:0] i_primary_control_register,
  input wire logic i_paging_en,
  input wire logic i_page_cache_disable,
  input wire logic i_page_write_through,
  input wire logic i_dir_cache_disable,
  input wire logic i_dir_write_through,
  input wire logic i_dir_access,
  input wire logic i_range_promote,
  // Core access request
  input wire logic [1:0] i_op,
  input wire logic i_icache,
  input wire logic [IDX_W-1:0] i_idx,
  input wire logic i_fill_shared,
  // Snoop request
  input wire logic [1:0] i_snoop,
  input wire logic [IDX_W-1:0] i_snoop_idx,
  // Access result
  output logic o_done,
  output logic o_hit,
  output logic o_bus_write,
  output logic o_cache_update,
  output logic o_fill_req,
  output logic [1:0] o_line_state,
  output logic o_mem_stale,
  output logic o_unique,
  // Snoop result
  output logic o_snoop_done,
  output logic o_snoop_hitm,
  output logic o_snoop_hit,
  // Fault and policy status
  output logic o_general_protection_fault,
  output logic [15:0] o_gp_err_code,
  output logic o_cacheable,
  output logic o_write_through,
  output logic o_strict_order
);
  typedef enum logic [1:0] {
    CCP_ST_IDLE = 2'h0,
    CCP_ST_LOOK = 2'h1
  } ccp_fsm_t;

  ccp_fsm_t fsm_q;
  logic [1:0] op_q;
  logic ic_q;
  logic [IDX_W-1:0] idx_q;
  logic fshr_q, cach_q, wt_q, prom_q;
  logic snp_q;
  logic [1:0] snk_q;
  logic [IDX_W-1:0] sidx_q;
  logic [1:0] d_rd, s_rd;
  logic i_rd;
  logic d_we, i_we;
  logic [IDX_W-1:0] d_widx, i_widx;
  logic [1:0] d_wdata;
  logic i_wdata;
  logic fill_dis, wt_inh, bad_mode, coherent;
  logic pcd_eff, pwt_eff;
  logic cach_now, wt_now;

  function automatic logic st_valid(input logic [1:0] s);
    return s != CCP_INV; // R05
  endfunction

  // Line held by no other cache
  function automatic logic st_unique(input logic [1:0] s);
    return s == CCP_MOD || s == CCP_EXC; // R06
  endfunction

  // Memory write needed for a data write to a line in state s
  function automatic logic wr_to_bus(input logic [1:0] s, input logic coh, input logic wt);
    if (!coh) begin
      return s == CCP_INV; // R20
    end
    return s == CCP_SHR || s == CCP_INV || wt; // R07 R19
  endfunction

  assign fill_dis = i_primary_control_register[CCP_CTRL_FILL_DIS_BIT];
  assign wt_inh = i_primary_control_register[CCP_CTRL_WT_INH_BIT];
  assign bad_mode = !fill_dis && wt_inh; // R18
  assign coherent = !(fill_dis && wt_inh); // R20

  // Attribute selection for page or directory accesses
  always_comb begin
    pcd_eff = i_dir_access ? i_dir_cache_disable : i_page_cache_disable; // R16
    pwt_eff = i_dir_access ? i_dir_write_through : i_page_write_through; // R16
  end

  // Paging gates the page attributes; the global bits gate both
  assign cach_now = !fill_dis && !(i_paging_en && pcd_eff); // R08 R14 R16
  assign wt_now = !wt_inh && i_paging_en && pwt_eff; // R13 R15 R16

  // Data/L2 state and snoop port share one memory; snoop lines read through the same read port
  ccp_state_mem #(.LINES(LINES), .IDX_W(IDX_W), .DW(2)) u_dmem (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_rd_idx(i_snoop != CCP_SN_NONE ? i_snoop_idx : i_idx),
    .o_rd_data(d_rd),
    .i_wr_en(d_we),
    .i_wr_idx(d_widx),
    .i_wr_data(d_wdata)
  ); // R01 R02

  // Instruction lines keep one bit: shared or invalid
  ccp_state_mem #(.LINES(LINES), .IDX_W(IDX_W), .DW(1)) u_imem (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_rd_idx(i_idx),
    .o_rd_data(i_rd),
    .i_wr_en(i_we),
    .i_wr_idx(i_widx),
    .i_wr_data(i_wdata)
  ); // R03
  assign s_rd = d_rd;

  // Request capture: snoops take priority over core accesses
  // A request meeting a snoop or the illegal mode is dropped with no result
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fsm_q <= CCP_ST_IDLE;
      snp_q <= 1'b0;
      op_q <= CCP_OP_NONE;
    end else begin
      snp_q <= (i_snoop != CCP_SN_NONE); // R09
      if (i_snoop == CCP_SN_NONE && i_op != CCP_OP_NONE && !bad_mode) begin
        fsm_q <= CCP_ST_LOOK;
        op_q <= i_op;
      end else begin
        fsm_q <= CCP_ST_IDLE;
        op_q <= CCP_OP_NONE;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ic_q <= 1'b0;
      idx_q <= '0;
      fshr_q <= 1'b0;
      cach_q <= 1'b0;
      wt_q <= 1'b0;
      prom_q <= 1'b0;
      snk_q <= CCP_SN_NONE;
      sidx_q <= '0;
    end else begin
      ic_q <= i_icache;
      idx_q <= i_idx;
      fshr_q <= i_fill_shared;
      cach_q <= cach_now; // R08 R14
      wt_q <= wt_now; // R13 R15
      prom_q <= i_range_promote;
      snk_q <= i_snoop;
      sidx_q <= i_snoop_idx;
    end
  end

  // State update decisions
  always_comb begin
    d_we = 1'b0;
    d_widx = idx_q;
    d_wdata = d_rd;
    i_we = 1'b0;
    i_widx = idx_q;
    i_wdata = 1'b0;
    if (snp_q) begin
      d_widx = sidx_q;
      i_widx = sidx_q;
      // Instruction copies go on every invalidating snoop, whatever the data state
      i_we = (snk_q == CCP_SN_INVAL); // R03 R04
      if (snk_q == CCP_SN_INVAL && st_valid(s_rd)) begin
        d_we = 1'b1;
        d_wdata = CCP_INV; // R06 R09
      end else if (snk_q == CCP_SN_READ && st_unique(s_rd)) begin
        d_we = coherent;
        d_wdata = CCP_SHR; // R06
      end
    end else if (fsm_q == CCP_ST_LOOK) begin
      unique case (op_q)
        CCP_OP_WRITE: begin
          i_we = 1'b1; // R04
          if (d_rd == CCP_EXC && !wt_q) begin
            d_we = 1'b1;
            d_wdata = CCP_MOD; // R07 R21
          end else if (d_rd == CCP_SHR && prom_q && coherent && !fill_dis && !wt_q) begin
            d_we = 1'b1;
            d_wdata = CCP_EXC; // R17
          end
        end
        CCP_OP_FILL: begin
          if (!ic_q && cach_q) begin
            d_we = 1'b1;
            d_wdata = fshr_q ? CCP_SHR : CCP_EXC; // R17
          end else if (ic_q && cach_q) begin
            i_we = 1'b1;
            i_wdata = 1'b1; // R03
          end
        end
        // Reads and idle cycles leave line states alone
        CCP_OP_NONE, CCP_OP_READ: begin
        end
      endcase
    end
  end

  // Access result registers
  // Line flags refresh every cycle and mean something only with o_done
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_done <= 1'b0;
      o_hit <= 1'b0;
      o_bus_write <= 1'b0;
      o_cache_update <= 1'b0;
      o_fill_req <= 1'b0;
      o_line_state <= CCP_STATE_RST;
      o_mem_stale <= 1'b0;
      o_unique <= 1'b0;
    end else begin
      o_done <= !snp_q && fsm_q == CCP_ST_LOOK;
      o_hit <= ic_q ? i_rd : st_valid(d_rd); // R05 R10
      o_bus_write <= 1'b0;
      o_cache_update <= 1'b0;
      o_fill_req <= 1'b0;
      o_line_state <= ic_q ? (i_rd ? CCP_SHR : CCP_INV) : d_rd;
      o_mem_stale <= !ic_q && d_rd == CCP_MOD; // R05
      o_unique <= !ic_q && st_unique(d_rd); // R06
      if (!snp_q && fsm_q == CCP_ST_LOOK) begin
        if (op_q == CCP_OP_WRITE && !ic_q) begin
          o_cache_update <= st_valid(d_rd); // R10 R17 R19
          o_bus_write <= wr_to_bus(d_rd, coherent, wt_q); // R07 R19 R20
        end
        if (op_q == CCP_OP_READ) begin
          o_fill_req <= (ic_q ? !i_rd : !st_valid(d_rd)) && cach_q; // R09 R17 R19
        end
      end
    end
  end

  // Snoop answers keep flowing regardless of fill-disable
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_snoop_done <= 1'b0;
      o_snoop_hitm <= 1'b0;
      o_snoop_hit <= 1'b0;
    end else begin
      o_snoop_done <= snp_q; // R09
      o_snoop_hitm <= snp_q && s_rd == CCP_MOD;
      o_snoop_hit <= snp_q && st_valid(s_rd);
    end
  end

  // Fault and policy status
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_general_protection_fault <= 1'b0;
      o_gp_err_code <= CCP_GP_ERR_CODE;
      o_cacheable <= 1'b0;
      o_write_through <= 1'b0;
      o_strict_order <= 1'b0;
    end else begin
      o_general_protection_fault <= bad_mode; // R18
      o_gp_err_code <= CCP_GP_ERR_CODE; // R18
      o_cacheable <= cach_now; // R08 R14 R16
      o_write_through <= wt_now; // R15 R16
      // Strict ordering is never forced by the global bits alone
      o_strict_order <= 1'b0; // R11
    end
  end
endmodule
`default_nettype wire

//--- pkg/ccp_pkg.sv
`default_nettype none
package ccp_pkg;
  // Coherency state encoding; invalid is the reset value
  typedef enum logic [1:0] {
    CCP_INV = 2'h0,
    CCP_SHR = 2'h1,
    CCP_EXC = 2'h2,
    CCP_MOD = 2'h3
  } ccp_mesi_t;

  // Access kinds presented by the core
  typedef enum logic [1:0] {
    CCP_OP_NONE  = 2'h0,
    CCP_OP_READ  = 2'h1,
    CCP_OP_WRITE = 2'h2,
    CCP_OP_FILL  = 2'h3
  } ccp_op_t;

  // Snoop kinds from the system bus
  typedef enum logic [1:0] {
    CCP_SN_NONE  = 2'h0,
    CCP_SN_READ  = 2'h1,
    CCP_SN_INVAL = 2'h2
  } ccp_snoop_t;

  // Field position of the fill-disable bit in the primary control register
  localparam int unsigned CCP_CTRL_FILL_DIS_BIT = 30;
  localparam int unsigned CCP_CTRL_WT_INH_BIT = 29;
  localparam logic [15:0] CCP_GP_ERR_CODE = 16'h0000;
  localparam int unsigned CCP_IDX_W = 6;
  localparam int unsigned CCP_LINES = 64;
  localparam logic [1:0] CCP_STATE_RST = 2'h0;
  localparam logic CCP_ISTATE_RST = 1'h0;
endpackage
`default_nettype wire

//--- src/ccp_state_mem.sv
`default_nettype none
module ccp_state_mem
  import ccp_pkg::*;
#(
  parameter int unsigned LINES = CCP_LINES,
  parameter int unsigned IDX_W = CCP_IDX_W,
  parameter int unsigned DW = 2
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Read port
  input wire logic [IDX_W-1:0] i_rd_idx,
  output logic [DW-1:0] o_rd_data,
  // Write port
  input wire logic i_wr_en,
  input wire logic [IDX_W-1:0] i_wr_idx,
  input wire logic [DW-1:0] i_wr_data
);
  logic [DW-1:0] mem_q [LINES];

  // Reset clears every line so all states start at zero
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < LINES; k++) begin
        mem_q[k] <= '0;
      end
    end else if (i_wr_en) begin
      mem_q[i_wr_idx] <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= '0;
    end else if (i_wr_en && i_wr_idx == i_rd_idx) begin
      o_rd_data <= i_wr_data;
    end else begin
      o_rd_data <= mem_q[i_rd_idx];
    end
  end
endmodule
`default_nettype wire

//--- verif/ccp_ctrl_chk.sv
`default_nettype none
module ccp_ctrl_chk
  import ccp_pkg::*;
(
  // Clock, reset and controls
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_primary_control_register,
  input wire logic i_paging_en,
  input wire logic [1:0] i_op,
  input wire logic [1:0] i_snoop,
  // Results
  input wire logic o_done,
  input wire logic o_hit,
  input wire logic o_bus_write,
  input wire logic o_fill_req,
  input wire logic [1:0] o_line_state,
  input wire logic o_mem_stale,
  input wire logic o_unique,
  input wire logic o_snoop_done,
  input wire logic o_general_protection_fault,
  input wire logic [15:0] o_gp_err_code,
  input wire logic o_cacheable,
  input wire logic o_strict_order
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic cd = i_primary_control_register[CCP_CTRL_FILL_DIS_BIT];
  wire logic nw = i_primary_control_register[CCP_CTRL_WT_INH_BIT];
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_take;
    i_op != 2'h0 && i_snoop == 2'h0 && !(!cd && nw);
  endsequence
  sequence s_read_done;
    o_done && $past(i_op, 2) == CCP_OP_READ;
  endsequence
  done_latency_a: assert property (s_take |-> ##2 o_done)
    else $error("access result missing");
  snoop_latency_a: assert property (i_snoop != 2'h0 |-> ##2 o_snoop_done)
    else $error("snoop result missing");
  gp_fault_a: assert property (1 |=>
    o_general_protection_fault == (!$past(cd) && $past(nw)))
    else $error("fault level wrong");
  gp_code_a: assert property (o_general_protection_fault |->
    o_gp_err_code == CCP_GP_ERR_CODE)
    else $error("fault code wrong");
  strict_order_a: assert property (!o_strict_order)
    else $error("strict order raised");
  no_fill_a: assert property (o_done && $past(cd, 2) |-> !o_fill_req)
    else $error("fill while disabled");
  miss_to_bus_a: assert property (o_done && !o_hit && $past(i_op, 2) == CCP_OP_WRITE |->
    o_bus_write)
    else $error("write miss not on bus");
  read_hit_a: assert property (s_read_done |-> o_hit == (o_line_state != CCP_INV))
    else $error("hit disagrees with state");
  stale_copy_a: assert property (s_read_done |-> o_mem_stale == (o_line_state == CCP_MOD))
    else $error("stale flag wrong");
  unique_line_a: assert property (s_read_done |->
    o_unique == (o_line_state inside {CCP_MOD, CCP_EXC}))
    else $error("unique flag wrong");
  cd_uncached_a: assert property (cd |=> !o_cacheable)
    else $error("cacheable while disabled");
  cd_cached_a: assert property (!cd && !nw && !i_paging_en |=> o_cacheable)
    else $error("not cacheable");
endmodule
bind ccp_ctrl ccp_ctrl_chk u_chk (.*);
`default_nettype wire

//--- verif/ccp_bus_agent.sv
`default_nettype none
module ccp_bus_agent
  import ccp_pkg::*;
(
  // Clock and snoop answer
  input wire logic i_ref_clk,
  input wire logic i_snoop_done,
  // Snoop request
  output logic [1:0] o_snoop = 2'h0,
  output logic [CCP_IDX_W-1:0] o_snoop_idx = 6'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  // One snoop cycle; the index lines take the inverted index once released
  task automatic snoop(input ccp_snoop_t k, input logic [CCP_IDX_W-1:0] x, output logic ok);
    ok = 1'h0;
    @(posedge i_ref_clk);
    o_snoop <= k;
    o_snoop_idx <= x;
    @(posedge i_ref_clk);
    o_snoop <= CCP_SN_NONE;
    o_snoop_idx <= ~x;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge i_ref_clk);
      #1;
      ok = (i_snoop_done === 1'h1);
    end
  endtask
endmodule
`default_nettype wire

//--- verif/ccp_ctrl_bench.sv
`default_nettype none
module ccp_ctrl_bench
  import ccp_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk = 1'h0, i_sys_rst = 1'h1, i_paging_en = 1'h0, i_page_cache_disable = 1'h0;
  logic i_page_write_through = 1'h0, i_dir_cache_disable = 1'h0, i_dir_write_through = 1'h0;
  logic i_dir_access = 1'h0, i_range_promote = 1'h0, i_icache = 1'h0, i_fill_shared = 1'h0;
  logic [31:0] i_primary_control_register = 32'h0;
  logic [1:0] i_op = 2'h0, i_snoop, o_line_state;
  logic [CCP_IDX_W-1:0] i_idx = 6'h0, i_snoop_idx;
  logic o_done, o_hit, o_bus_write, o_cache_update, o_fill_req, o_mem_stale, o_unique;
  logic o_snoop_done, o_snoop_hitm, o_snoop_hit, o_general_protection_fault;
  logic o_cacheable, o_write_through, o_strict_order;
  logic [15:0] o_gp_err_code;
  int num_errors = 0, checks = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  ccp_ctrl u_dut (.*);
  ccp_bus_agent u_bus (.i_ref_clk(i_ref_clk), .i_snoop_done(o_snoop_done),
    .o_snoop(i_snoop), .o_snoop_idx(i_snoop_idx));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic op(input ccp_op_t k, input logic ic, input logic [CCP_IDX_W-1:0] x,
    input logic e);
    logic seen;
    seen = 1'h0;
    @(posedge i_ref_clk);
    i_op <= k;
    i_icache <= ic;
    i_idx <= x;
    @(posedge i_ref_clk);
    i_op <= CCP_OP_NONE;
    for (int n = 0; n < 4 && !seen; n++) begin
      @(posedge i_ref_clk);
      #1;
      seen = (o_done === 1'h1);
    end
    chk(seen, e);
    if (e && !seen) end_sim;
  endtask
  task automatic sn(input ccp_snoop_t k, input logic [CCP_IDX_W-1:0] x);
    logic ok;
    u_bus.snoop(k, x, ok);
    chk(ok, 1'h1);
    if (!ok) end_sim;
  endtask
  task automatic mode(input logic [1:0] m);
    @(posedge i_ref_clk);
    i_primary_control_register[30:29] <= m;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask
  // Fields: fill-disable, paging, page cd, page wt, directory access, directory cd
  task automatic pol(input logic [5:0] v, input logic [1:0] e);
    @(posedge i_ref_clk);
    {i_primary_control_register[30], i_paging_en, i_page_cache_disable} <= v[5:3];
    {i_page_write_through, i_dir_access, i_dir_cache_disable} <= v[2:0];
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(o_cacheable, e[1]);
    if (e[1]) chk(o_write_through, e[0]);
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    op(CCP_OP_READ, 1'h0, 6'h01, 1'h1);
    chk(o_line_state, CCP_INV);
    chk(o_fill_req, 1'h1);
    op(CCP_OP_FILL, 1'h0, 6'h01, 1'h1);
    op(CCP_OP_WRITE, 1'h0, 6'h01, 1'h1);
    chk(o_bus_write, 1'h0);
    chk(o_cache_update, 1'h1);
    op(CCP_OP_READ, 1'h0, 6'h01, 1'h1);
    chk(o_line_state, CCP_MOD);
    chk(o_mem_stale, 1'h1);
    chk(o_unique, 1'h1);
    sn(CCP_SN_READ, 6'h01);
    chk(o_snoop_hitm, 1'h1);
    chk(o_snoop_hit, 1'h1);
    op(CCP_OP_READ, 1'h0, 6'h01, 1'h1);
    chk(o_line_state, CCP_SHR);
    chk(o_unique, 1'h0);
    i_range_promote <= 1'h1;
    op(CCP_OP_WRITE, 1'h0, 6'h01, 1'h1);
    i_range_promote <= 1'h0;
    chk(o_bus_write, 1'h1);
    chk(o_cache_update, 1'h1);
    op(CCP_OP_READ, 1'h0, 6'h01, 1'h1);
    chk(o_line_state, CCP_EXC);
    op(CCP_OP_WRITE, 1'h0, 6'h07, 1'h1);
    chk(o_bus_write, 1'h1);
    $display("test mesi done");
    i_fill_shared <= 1'h1;
    op(CCP_OP_FILL, 1'h1, 6'h04, 1'h1);
    op(CCP_OP_READ, 1'h1, 6'h04, 1'h1);
    chk(o_line_state, CCP_SHR);
    op(CCP_OP_WRITE, 1'h0, 6'h04, 1'h1);
    op(CCP_OP_READ, 1'h1, 6'h04, 1'h1);
    chk(o_hit, 1'h0);
    op(CCP_OP_FILL, 1'h0, 6'h05, 1'h1);
    i_fill_shared <= 1'h0;
    $display("test icache done");
    op(CCP_OP_FILL, 1'h0, 6'h03, 1'h1);
    op(CCP_OP_FILL, 1'h0, 6'h02, 1'h1);
    mode(2'h2);
    op(CCP_OP_READ, 1'h0, 6'h09, 1'h1);
    chk(o_fill_req, 1'h0);
    op(CCP_OP_READ, 1'h0, 6'h03, 1'h1);
    chk(o_hit, 1'h1);
    sn(CCP_SN_INVAL, 6'h03);
    chk(o_snoop_hit, 1'h1);
    sn(CCP_SN_READ, 6'h09);
    chk(o_snoop_hit, 1'h0);
    op(CCP_OP_READ, 1'h0, 6'h03, 1'h1);
    chk(o_hit, 1'h0);
    $display("test fill disable done");
    mode(2'h3);
    op(CCP_OP_WRITE, 1'h0, 6'h02, 1'h1);
    chk(o_bus_write, 1'h0);
    op(CCP_OP_READ, 1'h0, 6'h02, 1'h1);
    chk(o_line_state, CCP_MOD);
    op(CCP_OP_WRITE, 1'h0, 6'h05, 1'h1);
    chk(o_bus_write, 1'h0);
    op(CCP_OP_READ, 1'h0, 6'h05, 1'h1);
    chk(o_line_state, CCP_SHR);
    $display("test no coherency done");
    mode(2'h1);
    chk(o_general_protection_fault, 1'h1);
    chk(o_gp_err_code, 16'h0);
    op(CCP_OP_READ, 1'h0, 6'h02, 1'h0);
    mode(2'h0);
    chk(o_general_protection_fault, 1'h0);
    $display("test fault done");
    pol(6'h10, 2'h2);
    pol(6'h18, 2'h0);
    pol(6'h08, 2'h2);
    pol(6'h14, 2'h3);
    pol(6'h13, 2'h0);
    pol(6'h1a, 2'h2);
    i_dir_write_through <= 1'h1;
    pol(6'h12, 2'h3);
    pol(6'h30, 2'h0);
    $display("test policy done");
    end_sim;
  end
endmodule
`default_nettype wire
